// ### data_space_decoder_rom_window_tb_top.sv
// Purpose: directed test of the data-space decoder and its read window
// Assumes: CPU side driven 1 ns after the rising edge
// Notes: expectations come from the address map, never from the design
`timescale 1ns/1ns
`default_nettype none
module data_space_decoder_rom_window_tb_top
  import dsd_pkg::*;
;
  logic CLK = 1'b0, RST = 1'b1, CPU_RD = 1'b0, CPU_WR = 1'b0;
  logic [7:0] CPU_ADDR = 8'h00, CPU_WDATA = 8'h00;
  logic CPU_BUSY, CPU_RVALID, PM_RD, BANK_RD, BANK_WR, CORE_RD, CORE_WR, PERI_RD, PERI_WR;
  logic [7:0] CPU_RDATA, PM_RDATA, BANK_RDATA, CORE_RDATA, PERI_RDATA, DS_WDATA, CORE_ADDR;
  logic [11:0] PM_ADDR;
  logic [5:0] BANK_ADDR;
  logic [5:0] wbase = 6'h00;
  logic [4:0] PERI_SLOT;
  // reduced part: no memory-control slot, program memory ends early
  localparam logic [11:0] PM_LAST_SMALL = 12'h7FF;
  logic small_rvalid, small_pm_rd, small_peri_rd, small_peri_wr;
  logic [7:0] small_rdata;
  int miscompares = 0, n_checks = 0;
  // slot code is table position plus one; the base register is never read back
  localparam logic [7:0] PERI_TAB [27] = '{8'hC0, 8'hC1, 8'hC2, 8'hC4, 8'hC5, 8'hC6, 8'hC8, 8'hCC, 8'hCD,
    8'hCE, 8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD5, 8'hD6, 8'hD7, 8'hD9, 8'hDA, 8'hDB, 8'hDC, 8'hE0,
    8'hE1, 8'hE2, 8'hE8, 8'hEA};
  localparam logic [7:0] RSV_TAB [14] = '{8'hC3, 8'hC7, 8'hCA, 8'hCB, 8'hCF, 8'hD8, 8'hDD, 8'hDE, 8'hDF,
    8'hE3, 8'hE7, 8'hE9, 8'hEB, 8'hFE};
  localparam logic [7:0] CORE_TAB [5] = '{8'h80, 8'h83, 8'h84, 8'hBF, 8'hFF};

  // 100 MHz clock
  always #5 CLK = ~CLK;

  dsd_decoder #(.HAS_NVM(1'b1), .PM_LAST(12'hFFF)) dut_u (.CLK(CLK), .RST(RST), .CPU_ADDR(CPU_ADDR),
    .CPU_WDATA(CPU_WDATA), .CPU_RD(CPU_RD), .CPU_WR(CPU_WR), .CPU_BUSY(CPU_BUSY), .CPU_RDATA(CPU_RDATA),
    .CPU_RVALID(CPU_RVALID), .PM_ADDR(PM_ADDR), .PM_RD(PM_RD), .PM_RDATA(PM_RDATA), .BANK_ADDR(BANK_ADDR),
    .BANK_RD(BANK_RD), .BANK_WR(BANK_WR), .BANK_RDATA(BANK_RDATA), .CORE_ADDR(CORE_ADDR), .CORE_RD(CORE_RD),
    .CORE_WR(CORE_WR), .CORE_RDATA(CORE_RDATA), .PERI_SLOT(PERI_SLOT), .PERI_RD(PERI_RD), .PERI_WR(PERI_WR),
    .PERI_RDATA(PERI_RDATA), .DS_WDATA(DS_WDATA));

  dsd_target_model model_u (.CLK(CLK), .PM_ADDR(PM_ADDR), .PM_RD(PM_RD), .BANK_ADDR(BANK_ADDR),
    .BANK_RD(BANK_RD), .CORE_ADDR(CORE_ADDR), .CORE_RD(CORE_RD), .PERI_SLOT(PERI_SLOT), .PERI_RD(PERI_RD),
    .PM_RDATA(PM_RDATA), .BANK_RDATA(BANK_RDATA), .CORE_RDATA(CORE_RDATA), .PERI_RDATA(PERI_RDATA));

  // shares the model: its strobes match the full part except where it must stay quiet
  dsd_decoder #(.HAS_NVM(1'b0), .PM_LAST(PM_LAST_SMALL)) dut_small_u (.CLK(CLK), .RST(RST), .CPU_ADDR(CPU_ADDR),
    .CPU_WDATA(CPU_WDATA), .CPU_RD(CPU_RD), .CPU_WR(CPU_WR), .CPU_BUSY(), .CPU_RDATA(small_rdata),
    .CPU_RVALID(small_rvalid), .PM_ADDR(), .PM_RD(small_pm_rd), .PM_RDATA(PM_RDATA), .BANK_ADDR(),
    .BANK_RD(), .BANK_WR(), .BANK_RDATA(BANK_RDATA), .CORE_ADDR(), .CORE_RD(), .CORE_WR(),
    .CORE_RDATA(CORE_RDATA), .PERI_SLOT(), .PERI_RD(small_peri_rd), .PERI_WR(small_peri_wr),
    .PERI_RDATA(PERI_RDATA), .DS_WDATA());

  function automatic logic [4:0] slot_of(input logic [7:0] a);
    slot_of = 5'h00;
    for (int i = 0; i < 27; i++) if (PERI_TAB[i] == a) slot_of = 5'(i + 1);
  endfunction

  // 1 bank, 2 window, 3 core, 4 peripheral, 0 nothing
  function automatic logic [2:0] kind_of(input logic [7:0] a);
    if (a <= 8'h3F) kind_of = 3'h1;
    else if (a <= 8'h7F) kind_of = 3'h2;
    else if (a <= 8'hBF || a == 8'hFF) kind_of = 3'h3;
    else if (slot_of(a) != 5'h00) kind_of = 3'h4;
    else kind_of = 3'h0;
  endfunction

  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one CPU access: strobes checked in cycle 1, read answer timed to its edge
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
    logic [2:0] k;
    logic [4:0] s;
    logic [6:0] stb;
    logic [7:0] exp;
    logic [11:0] pm;
    logic [6:0] stb2;
    logic [7:0] exp2;
    int n;
    k = kind_of(a);
    s = slot_of(a);
    pm = {wbase, a[5:0]};
    case (k)
      3'h1: stb = wr ? 7'h10 : 7'h20;
      3'h2: stb = wr ? 7'h00 : 7'h40;
      3'h3: stb = wr ? 7'h04 : 7'h08;
      3'h4: stb = wr ? 7'h01 : ((s == 5'h07 || s == 5'h1A) ? 7'h00 : 7'h02);
      default: stb = 7'h00;
    endcase
    case (stb)
      7'h20: exp = {2'b10, a[5:0]};
      7'h40: exp = pm[7:0] ^ {pm[11:8], 4'h5};
      7'h08: exp = a ^ 8'h3C;
      7'h02: exp = {3'b111, s};
      default: exp = 8'h00;
    endcase
    // reduced part: memory-control slot gone, window past its last address answers zero
    stb2 = stb;
    if (a == NVM_CONTROL_ADDR) stb2 = 7'h00;
    if (k == 3'h2 && pm > PM_LAST_SMALL) stb2 = 7'h00;
    exp2 = (stb2 == stb) ? exp : 8'h00;
    @(posedge CLK);
    #1;
    CPU_ADDR = a;
    CPU_WDATA = d;
    CPU_RD = ~wr;
    CPU_WR = wr;
    @(posedge CLK);
    #1;
    CPU_RD = 1'b0;
    CPU_WR = 1'b0;
    chk("strobes", {5'h00, stb}, {5'h00, PM_RD, BANK_RD, BANK_WR, CORE_RD, CORE_WR, PERI_RD, PERI_WR});
    chk("busy", 12'h001, {11'h000, CPU_BUSY});
    chk("small_strobes", {9'h000, stb2[6], stb2[1], stb2[0]}, {9'h000, small_pm_rd, small_peri_rd, small_peri_wr});
    if (k == 3'h1) chk("bank_addr", {6'h00, a[5:0]}, {6'h00, BANK_ADDR});
    if (k == 3'h2 && !wr) chk("pm_addr", pm, PM_ADDR);
    if (k == 3'h3) chk("core_addr", {4'h0, a}, {4'h0, CORE_ADDR});
    if (k == 3'h4) chk("peri_slot", {7'h00, s}, {7'h00, PERI_SLOT});
    if (wr) chk("wdata", {4'h0, d}, {4'h0, DS_WDATA});
    // only the low six bits move the window
    if (wr && a == ROM_WINDOW_BASE_ADDR) wbase = d[5:0];
    if (!wr) begin
      for (n = 1; n < 8 && CPU_RVALID !== 1'b1; n++) begin
        @(posedge CLK);
        #1;
      end
      chk("latency", 12'h003, 12'(n));
      chk("rdata", {4'h0, exp}, {4'h0, CPU_RDATA});
      chk("small_rdata", {3'h0, 1'b1, exp2}, {3'h0, small_rvalid, small_rdata});
    end
  endtask

  task automatic sweep(input logic [7:0] a);
    access(1'b1, a, a ^ 8'h5A);
    access(1'b0, a, 8'h00);
  endtask

  task automatic report_and_stop;
    if (miscompares == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // main sequence: reset, window, bank, core, peripherals, reserved holes
  initial begin
    repeat (5) @(posedge CLK);
    #1;
    chk("reset_strobes", 12'h000, {CPU_BUSY, CPU_RVALID, PM_RD, BANK_RD, BANK_WR, CORE_RD, CORE_WR, 5'h00});
    chk("reset_data", 12'h000, {CPU_RDATA, 4'h0});
    RST = 1'b0;
    access(1'b1, 8'h84, 8'h02);
    access(1'b1, ROM_WINDOW_BASE_ADDR, 8'hC2);
    access(1'b0, 8'h45, 8'h00);
    access(1'b0, 8'h40, 8'h00);
    access(1'b0, 8'h7F, 8'h00);
    access(1'b1, ROM_WINDOW_BASE_ADDR, 8'h03);
    access(1'b0, 8'h40, 8'h00);
    access(1'b1, ROM_WINDOW_BASE_ADDR, 8'h3F);
    access(1'b0, 8'h7F, 8'h00);
    access(1'b1, ROM_WINDOW_BASE_ADDR, 8'h00);
    access(1'b0, 8'h40, 8'h00);
    sweep(8'h00);
    sweep(8'h3F);
    for (int i = 0; i < 5; i++) sweep(CORE_TAB[i]);
    for (int i = 0; i < 27; i++) sweep(PERI_TAB[i]);
    for (int i = 0; i < 14; i++) sweep(RSV_TAB[i]);
    report_and_stop();
  end

  // watchdog: the whole run needs well under 2000 cycles
  initial begin
    #50000;
    miscompares++;
    report_and_stop();
  end
endmodule // data_space_decoder_rom_window_tb_top
`default_nettype wire

// ### dsd_decoder.sv
// Purpose: data-space address decoder with the program-memory read window
// Assumes: CPU and all targets on CLK; targets answer reads one cycle after their strobe
// Notes: one access in flight; CPU_BUSY holds off the next request
//
// What this block does
// - window reads 40h-7Fh come from program memory
// - window reaches program memory 000h to FFFh
// - base register write moves window 64 bytes
// - address is base then low six bits
// - base at C9h, bits 5-0 used
// - base register is not reset
// - port data registers at C0h-C2h
// - port direction registers at C4h-C6h
// - port option registers at CCh-CEh
// - converter result D0h, control D1h
// - timer prescaler, counter, status at D2h-D4h
// - reload timer mode D5h, status D6h-D7h
// - reload timer reload, compare, load D9h-DBh
// - serial data E0h, divider E1h, mode E2h
// - bank select E8h, memory control EAh
// - oscillator control at DCh
// - 00h-3Fh go to selected bank page
`timescale 1ns/1ns
`default_nettype none
module dsd_decoder
  import dsd_pkg::*;
#(
  parameter bit HAS_NVM = 1'b1,
  parameter logic [11:0] PM_LAST = PM_LAST_DEF
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] CPU_ADDR,
  input wire logic [7:0] CPU_WDATA,
  input wire logic CPU_RD,
  input wire logic CPU_WR,
  output logic CPU_BUSY,
  output logic [7:0] CPU_RDATA,
  output logic CPU_RVALID,
  output logic [11:0] PM_ADDR,
  output logic PM_RD,
  input wire logic [7:0] PM_RDATA,
  output logic [5:0] BANK_ADDR,
  output logic BANK_RD,
  output logic BANK_WR,
  input wire logic [7:0] BANK_RDATA,
  output logic [7:0] CORE_ADDR,
  output logic CORE_RD,
  output logic CORE_WR,
  input wire logic [7:0] CORE_RDATA,
  output logic [4:0] PERI_SLOT,
  output logic PERI_RD,
  output logic PERI_WR,
  input wire logic [7:0] PERI_RDATA,
  output logic [7:0] DS_WDATA
);

  dsd_state_t state, next_state;
  dsd_target_t tgt, next_tgt;
  dsd_slot_t slot, next_slot;
  logic req_wr, next_req_wr;
  logic req_rd, next_req_rd;
  logic pm_ok, next_pm_ok;
  logic [7:0] req_addr, next_req_addr;
  logic [7:0] wdata, next_wdata;
  logic [11:0] pm_addr, next_pm_addr;
  logic [7:0] rdata, next_rdata;
  logic rvalid, next_rvalid;
  logic [WIN_POS_W-1:0] win_base;
  logic wb_we;
  logic take;
  dsd_target_t dec_tgt;
  dsd_slot_t dec_slot;

  // peripheral slot lookup; the memory-control slot vanishes on the part without it
  always_comb begin
    case (CPU_ADDR)
      PA_DATA_ADDR: dec_slot = SLOT_PA_DATA;
      PB_DATA_ADDR: dec_slot = SLOT_PB_DATA;
      PC_DATA_ADDR: dec_slot = SLOT_PC_DATA;
      PA_DIR_ADDR: dec_slot = SLOT_PA_DIR;
      PB_DIR_ADDR: dec_slot = SLOT_PB_DIR;
      PC_DIR_ADDR: dec_slot = SLOT_PC_DIR;
      IRQ_OPT_ADDR: dec_slot = SLOT_IRQ_OPT;
      PA_OPT_ADDR: dec_slot = SLOT_PA_OPT;
      PB_OPT_ADDR: dec_slot = SLOT_PB_OPT;
      PC_OPT_ADDR: dec_slot = SLOT_PC_OPT;
      ADC_RESULT_ADDR: dec_slot = SLOT_ADC_RES;
      ADC_CTRL_ADDR: dec_slot = SLOT_ADC_CTL;
      TMR_PRESC_ADDR: dec_slot = SLOT_TMR_PSC;
      TMR_COUNT_ADDR: dec_slot = SLOT_TMR_CNT;
      TMR_STAT_ADDR: dec_slot = SLOT_TMR_STA;
      ART_MODE_ADDR: dec_slot = SLOT_ART_MOD;
      ART_STAT1_ADDR: dec_slot = SLOT_ART_SC1;
      ART_STAT2_ADDR: dec_slot = SLOT_ART_SC2;
      ART_RELOAD_ADDR: dec_slot = SLOT_ART_RLD;
      ART_COMPARE_ADDR: dec_slot = SLOT_ART_CMP;
      ART_LOAD_ADDR: dec_slot = SLOT_ART_LD;
      OSC_CTRL_ADDR: dec_slot = SLOT_OSC_CTL;
      SER_DATA_ADDR: dec_slot = SLOT_SER_DAT;
      SER_DIV_ADDR: dec_slot = SLOT_SER_DIV;
      SER_MODE_ADDR: dec_slot = SLOT_SER_MOD;
      BANK_PAGE_SELECT_ADDR: dec_slot = SLOT_BANK_SEL;
      NVM_CONTROL_ADDR: dec_slot = HAS_NVM ? SLOT_NVM_CTL : SLOT_NONE;
      default: dec_slot = SLOT_NONE;
    endcase
  end

  // region decode
  always_comb begin
    if (CPU_ADDR <= BANK_LAST) begin
      dec_tgt = TGT_BANK;
    end else if (CPU_ADDR <= WIN_LAST) begin
      dec_tgt = TGT_ROM;
    end else if (CPU_ADDR <= CORE_RAM_LAST || CPU_ADDR == ACC_ADDR) begin
      dec_tgt = TGT_CORE;
    end else if (CPU_ADDR == ROM_WINDOW_BASE_ADDR) begin
      dec_tgt = TGT_WBASE;
    end else if (dec_slot != SLOT_NONE) begin
      dec_tgt = TGT_PERI;
    end else begin
      dec_tgt = TGT_NONE;
    end
  end

  // a request is taken only while idle; write wins if both strobes are high
  assign take = (state == ST_IDLE) && (CPU_RD || CPU_WR);
  assign CPU_BUSY = (state != ST_IDLE);

  // request capture and sequencing
  always_comb begin
    next_state = state;
    next_tgt = tgt;
    next_slot = slot;
    next_req_wr = req_wr;
    next_req_rd = req_rd;
    next_req_addr = req_addr;
    next_wdata = wdata;
    next_pm_addr = pm_addr;
    next_pm_ok = pm_ok;
    case (state)
      ST_IDLE: begin
        if (take) begin
          next_state = ST_ISSUE;
          next_tgt = dec_tgt;
          next_slot = dec_slot;
          next_req_wr = CPU_WR;
          next_req_rd = CPU_RD && !CPU_WR;
          next_req_addr = CPU_ADDR;
          next_wdata = CPU_WDATA;
          next_pm_addr = {win_base, CPU_ADDR[WIN_OFS_W-1:0]};
          next_pm_ok = ({win_base, CPU_ADDR[WIN_OFS_W-1:0]} <= PM_LAST);
        end
      end
      ST_ISSUE: begin
        next_state = req_rd ? ST_CAPT : ST_IDLE;
      end
      ST_CAPT: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // request registers; reset clears every one of them, not only the fsm
  always_ff @(posedge CLK) begin
    if (RST) begin
      state <= ST_IDLE;
      tgt <= TGT_NONE;
      slot <= SLOT_NONE;
      req_wr <= 1'b0;
      req_rd <= 1'b0;
      req_addr <= 8'h00;
      wdata <= 8'h00;
      pm_addr <= 12'h000;
      pm_ok <= 1'b0;
    end else begin
      state <= next_state;
      tgt <= next_tgt;
      slot <= next_slot;
      req_wr <= next_req_wr;
      req_rd <= next_req_rd;
      req_addr <= next_req_addr;
      wdata <= next_wdata;
      pm_addr <= next_pm_addr;
      pm_ok <= next_pm_ok;
    end
  end

  // target strobes; program memory is never written through the window
  assign PM_RD = (state == ST_ISSUE) && req_rd && (tgt == TGT_ROM) && pm_ok;
  assign BANK_RD = (state == ST_ISSUE) && req_rd && (tgt == TGT_BANK);
  assign BANK_WR = (state == ST_ISSUE) && req_wr && (tgt == TGT_BANK);
  assign CORE_RD = (state == ST_ISSUE) && req_rd && (tgt == TGT_CORE);
  assign CORE_WR = (state == ST_ISSUE) && req_wr && (tgt == TGT_CORE);
  // write-only slots never see a read strobe, a read there returns the fill value
  assign PERI_RD = (state == ST_ISSUE) && req_rd && (tgt == TGT_PERI)
                   && (slot != SLOT_IRQ_OPT) && (slot != SLOT_BANK_SEL);
  assign PERI_WR = (state == ST_ISSUE) && req_wr && (tgt == TGT_PERI);
  assign wb_we = (state == ST_ISSUE) && req_wr && (tgt == TGT_WBASE);
  assign PM_ADDR = pm_addr;
  assign BANK_ADDR = req_addr[5:0];
  assign CORE_ADDR = req_addr;
  assign PERI_SLOT = slot;
  assign DS_WDATA = wdata;

  // the base register itself
  dsd_window_base u_wbase (
    .clk(CLK),
    .we(wb_we),
    .wdata(wdata),
    .base(win_base)
  );

  // read return: data is picked from the target one cycle after its strobe
  always_comb begin
    next_rdata = rdata;
    next_rvalid = 1'b0;
    if (state == ST_CAPT) begin
      next_rvalid = 1'b1;
      case (tgt)
        TGT_ROM: next_rdata = pm_ok ? PM_RDATA : READ_FILL;
        TGT_BANK: next_rdata = BANK_RDATA;
        TGT_CORE: next_rdata = CORE_RDATA;
        TGT_PERI: next_rdata = ((slot == SLOT_IRQ_OPT) || (slot == SLOT_BANK_SEL)) ? READ_FILL : PERI_RDATA;
        default: next_rdata = READ_FILL;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  assign CPU_RDATA = rdata;
  assign CPU_RVALID = rvalid;

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence rom_take_s;
    take && !CPU_WR && (CPU_ADDR >= WIN_FIRST) && (CPU_ADDR <= WIN_LAST);
  endsequence

  sequence base_write_s;
    take && CPU_WR && (CPU_ADDR == ROM_WINDOW_BASE_ADDR);
  endsequence

  rom_addr_form_a: assert property (
    rom_take_s |=> (PM_ADDR == {$past(win_base), $past(CPU_ADDR[5:0])}) && (state == ST_ISSUE))
    else $error("window address not formed from base and offset");

  rom_strobe_a: assert property (
    rom_take_s ##1 pm_ok |-> PM_RD && !BANK_RD && !CORE_RD && !PERI_RD)
    else $error("window read not sent to program memory");

  rom_data_a: assert property (
    rom_take_s ##1 pm_ok ##1 1'b1 |=> CPU_RVALID && (CPU_RDATA == $past(PM_RDATA)))
    else $error("window read data not from program memory");

  base_load_a: assert property (
    base_write_s |-> ##2 (win_base == $past(CPU_WDATA[5:0], 2)))
    else $error("window base not loaded with low six bits");

  base_hold_a: assert property (
    !wb_we |=> $stable(win_base))
    else $error("window base changed without a write");

  bank_route_a: assert property (
    take && (CPU_ADDR <= BANK_LAST) |=> (BANK_RD || BANK_WR) && (BANK_ADDR == $past(CPU_ADDR[5:0])))
    else $error("low region access not sent to bank page");

  port_data_a: assert property (
    take && (CPU_ADDR == PC_DATA_ADDR) |=> (PERI_SLOT == SLOT_PC_DATA) && (PERI_RD || PERI_WR))
    else $error("port data slot misrouted");

  serial_div_a: assert property (
    take && (CPU_ADDR == SER_DIV_ADDR) |=> (PERI_SLOT == SLOT_SER_DIV))
    else $error("serial divider slot misrouted");

  reserved_quiet_a: assert property (
    take && (dec_tgt == TGT_NONE) |=> !(BANK_WR || CORE_WR || PERI_WR || wb_we) [*2])
    else $error("reserved address produced a write strobe");

  wo_read_a: assert property (
    take && CPU_RD && !CPU_WR && (CPU_ADDR == IRQ_OPT_ADDR) |=> !PERI_RD ##2 (CPU_RDATA == READ_FILL))
    else $error("write-only slot answered a read");

  read_latency_a: assert property (
    take && CPU_RD && !CPU_WR |=> !CPU_RVALID [*2] ##1 CPU_RVALID)
    else $error("read answer not on third cycle");

endmodule // dsd_decoder
`default_nettype wire

// ### dsd_pkg.sv
// Purpose: constants for the data-space decoder and program-memory read window
// Assumes: 8-bit data space, 12-bit program memory address, one core clock
// Notes: slot codes name the peripheral register slots seen on PERI_SLOT
package dsd_pkg;

  // data-space regions
  localparam logic [7:0] BANK_LAST = 8'h3F;
  localparam logic [7:0] WIN_FIRST = 8'h40;
  localparam logic [7:0] WIN_LAST = 8'h7F;
  localparam logic [7:0] CORE_IDX_FIRST = 8'h80;
  localparam logic [7:0] CORE_RAM_LAST = 8'hBF;
  localparam logic [7:0] ACC_ADDR = 8'hFF;

  // register addresses
  localparam logic [7:0] PA_DATA_ADDR = 8'hC0;
  localparam logic [7:0] PB_DATA_ADDR = 8'hC1;
  localparam logic [7:0] PC_DATA_ADDR = 8'hC2;
  localparam logic [7:0] PA_DIR_ADDR = 8'hC4;
  localparam logic [7:0] PB_DIR_ADDR = 8'hC5;
  localparam logic [7:0] PC_DIR_ADDR = 8'hC6;
  localparam logic [7:0] IRQ_OPT_ADDR = 8'hC8;
  localparam logic [7:0] ROM_WINDOW_BASE_ADDR = 8'hC9;
  localparam logic [7:0] PA_OPT_ADDR = 8'hCC;
  localparam logic [7:0] PB_OPT_ADDR = 8'hCD;
  localparam logic [7:0] PC_OPT_ADDR = 8'hCE;
  localparam logic [7:0] ADC_RESULT_ADDR = 8'hD0;
  localparam logic [7:0] ADC_CTRL_ADDR = 8'hD1;
  localparam logic [7:0] TMR_PRESC_ADDR = 8'hD2;
  localparam logic [7:0] TMR_COUNT_ADDR = 8'hD3;
  localparam logic [7:0] TMR_STAT_ADDR = 8'hD4;
  localparam logic [7:0] ART_MODE_ADDR = 8'hD5;
  localparam logic [7:0] ART_STAT1_ADDR = 8'hD6;
  localparam logic [7:0] ART_STAT2_ADDR = 8'hD7;
  localparam logic [7:0] ART_RELOAD_ADDR = 8'hD9;
  localparam logic [7:0] ART_COMPARE_ADDR = 8'hDA;
  localparam logic [7:0] ART_LOAD_ADDR = 8'hDB;
  localparam logic [7:0] OSC_CTRL_ADDR = 8'hDC;
  localparam logic [7:0] SER_DATA_ADDR = 8'hE0;
  localparam logic [7:0] SER_DIV_ADDR = 8'hE1;
  localparam logic [7:0] SER_MODE_ADDR = 8'hE2;
  localparam logic [7:0] BANK_PAGE_SELECT_ADDR = 8'hE8;
  localparam logic [7:0] NVM_CONTROL_ADDR = 8'hEA;

  // window base field
  localparam int WIN_POS_LSB = 0;
  localparam int WIN_POS_W = 6;
  localparam int WIN_OFS_W = 6;
  localparam int PM_ADDR_W = 12;
  localparam logic [11:0] PM_FIRST = 12'h000;
  localparam logic [11:0] PM_LAST_DEF = 12'hFFF;
  localparam logic [7:0] READ_FILL = 8'h00;

  // read latency in cycles from request to CPU_RVALID
  localparam int RD_LATENCY = 3;

  // peripheral slot codes, zero means no slot
  typedef enum logic [4:0] {
    SLOT_NONE = 5'h00, SLOT_PA_DATA = 5'h01, SLOT_PB_DATA = 5'h02, SLOT_PC_DATA = 5'h03,
    SLOT_PA_DIR = 5'h04, SLOT_PB_DIR = 5'h05, SLOT_PC_DIR = 5'h06, SLOT_IRQ_OPT = 5'h07,
    SLOT_PA_OPT = 5'h08, SLOT_PB_OPT = 5'h09, SLOT_PC_OPT = 5'h0A, SLOT_ADC_RES = 5'h0B,
    SLOT_ADC_CTL = 5'h0C, SLOT_TMR_PSC = 5'h0D, SLOT_TMR_CNT = 5'h0E, SLOT_TMR_STA = 5'h0F,
    SLOT_ART_MOD = 5'h10, SLOT_ART_SC1 = 5'h11, SLOT_ART_SC2 = 5'h12, SLOT_ART_RLD = 5'h13,
    SLOT_ART_CMP = 5'h14, SLOT_ART_LD = 5'h15, SLOT_OSC_CTL = 5'h16, SLOT_SER_DAT = 5'h17,
    SLOT_SER_DIV = 5'h18, SLOT_SER_MOD = 5'h19, SLOT_BANK_SEL = 5'h1A, SLOT_NVM_CTL = 5'h1B
  } dsd_slot_t;

  // where an access goes
  typedef enum logic [2:0] {
    TGT_NONE = 3'h0, TGT_BANK = 3'h1, TGT_ROM = 3'h2, TGT_CORE = 3'h3, TGT_PERI = 3'h4, TGT_WBASE = 3'h5
  } dsd_target_t;

  // fsm states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001, ST_ISSUE = 3'b010, ST_CAPT = 3'b100
  } dsd_state_t;

endpackage : dsd_pkg

// ### dsd_target_model.sv
// Purpose: target-side model answering the decoder's read strobes
// Assumes: every target answers in the cycle after its strobe
// Notes: outside that cycle the lines show the inverse of the last answer
`timescale 1ns/1ns
`default_nettype none
module dsd_target_model (
  input wire logic CLK,
  input wire logic [11:0] PM_ADDR,
  input wire logic PM_RD,
  input wire logic [5:0] BANK_ADDR,
  input wire logic BANK_RD,
  input wire logic [7:0] CORE_ADDR,
  input wire logic CORE_RD,
  input wire logic [4:0] PERI_SLOT,
  input wire logic PERI_RD,
  output logic [7:0] PM_RDATA,
  output logic [7:0] BANK_RDATA,
  output logic [7:0] CORE_RDATA,
  output logic [7:0] PERI_RDATA
);
  logic [3:0] vld = 4'h0;
  logic [7:0] pm_q = 8'hA5, bk_q = 8'hA5, co_q = 8'hA5, pe_q = 8'hA5;

  // answers derive from the address, so a wrong address gives wrong data
  always @(posedge CLK) begin
    vld <= {PM_RD, BANK_RD, CORE_RD, PERI_RD};
    if (PM_RD) pm_q <= PM_ADDR[7:0] ^ {PM_ADDR[11:8], 4'h5};
    if (BANK_RD) bk_q <= {2'b10, BANK_ADDR};
    if (CORE_RD) co_q <= CORE_ADDR ^ 8'h3C;
    if (PERI_RD) pe_q <= {3'b111, PERI_SLOT};
  end

  // stale data is inverted so a late sample never matches
  assign PM_RDATA = vld[3] ? pm_q : ~pm_q;
  assign BANK_RDATA = vld[2] ? bk_q : ~bk_q;
  assign CORE_RDATA = vld[1] ? co_q : ~co_q;
  assign PERI_RDATA = vld[0] ? pe_q : ~pe_q;
endmodule // dsd_target_model
`default_nettype wire

// ### dsd_window_base.sv
// Purpose: write-only program-memory window base register
// Assumes: write enable comes from the decoder on the same clock
// Notes: deliberately has no reset, the contents are unknown until written
`timescale 1ns/1ns
`default_nettype none
module dsd_window_base
  import dsd_pkg::*;
(
  input wire logic clk,
  input wire logic we,
  input wire logic [7:0] wdata,
  output logic [WIN_POS_W-1:0] base
);

  logic [WIN_POS_W-1:0] next_base;

  // only bits 5..0 are kept, the two upper data bits are dropped
  always_comb begin
    next_base = base;
    if (we) begin
      next_base = wdata[WIN_POS_LSB +: WIN_POS_W];
    end
  end

  // no reset term: software has to load it before the first window read
  always_ff @(posedge clk) begin
    base <= next_base;
  end

endmodule // dsd_window_base
`default_nettype wire
